// ---- src/dac_supply_pkg.sv ----
/*
 package for the converter supply sequencer and register memory:
 word indexes of the memory map, field positions, reset values, states.
 assumes the apb byte address is four times the word index.
*/
package dac_supply_pkg;
    // ==========================================
    // memory map word indexes
    localparam logic [5:0] IDX_DAC0 = 6'h00;
    localparam logic [5:0] IDX_DAC1 = 6'h01;
    localparam logic [5:0] IDX_VREF = 6'h08;
    localparam logic [5:0] IDX_PDN = 6'h09;
    localparam logic [5:0] IDX_GAIN_STAT = 6'h0a;
    localparam logic [5:0] IDX_LOCK_STAT = 6'h0b;
    localparam logic [5:0] IDX_NV_DAC0 = 6'h10;
    localparam logic [5:0] IDX_NV_DAC1 = 6'h11;
    localparam logic [5:0] IDX_NV_VREF = 6'h18;
    localparam logic [5:0] IDX_NV_PDN = 6'h19;
    localparam logic [5:0] IDX_NV_GAIN_ADDR = 6'h1a;
    localparam logic [5:0] IDX_HV_CONFIG = 6'h20;
    localparam int APB_IDX_LSB = 2;
    // ==========================================
    // field positions
    localparam int POR_FLAG_BIT = 7;
    localparam int GAIN_LSB = 8;
    localparam int SLAVE_ADDR_W = 7;
    localparam int ADDR_LOCK_BIT = 4;
    localparam int WORD_W = 16;
    localparam int CFG_W = 5;
    // ==========================================
    // values
    localparam logic [3:0] PDN_SAFE = 4'hf;
    localparam logic [3:0] SEL_RESET = 4'h0;
    localparam logic [1:0] GAIN_RESET = 2'h0;
    localparam logic [4:0] PTR_RESET = 5'h00;
    localparam logic [CFG_W-1:0] CFG_RESET = 5'h00;
    localparam logic [SLAVE_ADDR_W-1:0] SLAVE_ADDR_RESET = 7'h60;
    localparam int PORD_CYCLES_DEFAULT = 100;
    // ==========================================
    // sequencer states
    typedef enum logic [1:0]
    {
        ST_OFF = 2'b00,
        ST_HOLD = 2'b01,
        ST_RUN = 2'b10
    } seq_state_t;
endpackage

// ---- src/dac_supply_reset_memory_init.sv ----
/*
 supply trip sequencer and 16-bit register memory of a 1/2 channel
 voltage output converter, reached over an apb slave.
 assumes supply_good comes from an analog trip detector, asynchronous
 to pclk; strobe and high voltage pins are asynchronous too.
*/
// Local design decisions: register access over APB and the register offsets.
// Notes on behaviour
// - supply rise copies stored codes to volatile
// - supply rise reloads reference, power-down, gain
// - supply rise sets reset-occurred flag
// - commands refused until hold-off timer expires
// - supply rise forces memory pointer to zero
// - supply fall disables interface until next rise
// - supply fall blocks new stored writes
// - supply fall forces power-down select to 11
// - supply fall clears volatile output codes
// - supply fall clears reference and gain selects
// - one trip input, direction tells events apart
// - recovery after fall reruns full rise sequence
// - every memory location is sixteen bits
// - five config bits outside ordinary map
// - six volatile locations incl. status, lock
// - code width 8/10/12, channels 1/2
// - strobe moves held codes to outputs
// - gain bit selects unity or double
// - reference select among four sources
// - reads and writes refused below full supply
// - reserved access nacked, reads ones in low CODE_W bits
// - stored write starts at command completion
// - stored write leaves volatile copy unchanged
`timescale 1ns/1ps
module dac_supply_reset_memory_init
    import dac_supply_pkg::*;
#(
    parameter int CODE_W = 12,
    parameter int CHANNELS = 2,
    parameter int PORD_CYCLES = PORD_CYCLES_DEFAULT
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic supply_good,
    input wire logic output_update_strobe,
    input wire logic high_voltage_command_input,
    output logic [CODE_W-1:0] dac_code0,
    output logic [CODE_W-1:0] dac_code1,
    output logic [3:0] reference_source_select,
    output logic [3:0] power_down_select,
    output logic [1:0] output_gain_select,
    output logic interface_ready,
    output logic nv_write_pulse,
    output logic [4:0] memory_pointer
);
    // ==========================================
    // constants
    localparam int CNT_W = $clog2(PORD_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(PORD_CYCLES - 1);
    localparam logic [CODE_W-1:0] CODE_MID = {1'b0, {(CODE_W-1){1'b1}}};
    localparam logic [CODE_W-1:0] CODE_ZERO = '0;
    localparam logic [WORD_W-1:0] RSV_READ = WORD_W'({CODE_W{1'b1}});
    // ==========================================
    // pin synchronisers
    logic sg_meta_reg, sg_sync_reg, sg_prev_reg;
    logic strobe_meta_reg, strobe_sync_reg;
    logic hv_meta_reg, hv_sync_reg;
    logic por_event, bor_event;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sg_meta_reg <= 1'b0;
            sg_sync_reg <= 1'b0;
            sg_prev_reg <= 1'b0;
            strobe_meta_reg <= 1'b0;
            strobe_sync_reg <= 1'b0;
            hv_meta_reg <= 1'b0;
            hv_sync_reg <= 1'b0;
        end
        else
        begin
            sg_meta_reg <= supply_good;
            sg_sync_reg <= sg_meta_reg;
            sg_prev_reg <= sg_sync_reg;
            strobe_meta_reg <= output_update_strobe;
            strobe_sync_reg <= strobe_meta_reg;
            hv_meta_reg <= high_voltage_command_input;
            hv_sync_reg <= hv_meta_reg;
        end
    end

    // one detector, split by direction of crossing
    assign por_event = sg_sync_reg & ~sg_prev_reg;
    assign bor_event = ~sg_sync_reg & sg_prev_reg;
    // ==========================================
    // sequencer
    seq_state_t state_reg;
    logic [CNT_W-1:0] hold_cnt_reg;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= ST_OFF;
            hold_cnt_reg <= '0;
        end
        else if (bor_event)
            state_reg <= ST_OFF;
        else if (por_event)
        begin
            state_reg <= ST_HOLD;
            hold_cnt_reg <= CNT_LOAD;
        end
        else
        begin
            unique case (state_reg)
                ST_OFF: state_reg <= ST_OFF;
                ST_HOLD:
                begin
                    if (hold_cnt_reg == '0)
                        state_reg <= ST_RUN;
                    else
                        hold_cnt_reg <= hold_cnt_reg - 1'b1;
                end
                ST_RUN: state_reg <= ST_RUN;
                default: state_reg <= ST_OFF;
            endcase
        end
    end

    // ==========================================
    // storage, 16-bit words in the map plus the config bits outside it
    logic [CODE_W-1:0] dac_hold_reg [2];
    logic [CODE_W-1:0] nv_dac_reg [2];
    logic [3:0] vref_reg, pdn_reg, nv_vref_reg, nv_pdn_reg;
    logic [1:0] gain_reg, nv_gain_reg;
    logic por_flag_reg;
    logic [SLAVE_ADDR_W-1:0] nv_addr_reg;
    logic [CFG_W-1:0] cfg_reg;
    // ==========================================
    // apb decode
    logic [5:0] idx;
    logic mapped, locked, refuse, done, wr_ok;
    logic [WORD_W-1:0] rword;
    function automatic logic is_mapped(input logic [5:0] i);
        is_mapped = (i == IDX_DAC0) || (i == IDX_NV_DAC0)
            || (((i == IDX_DAC1) || (i == IDX_NV_DAC1)) && (CHANNELS == 2))
            || (i == IDX_VREF) || (i == IDX_PDN) || (i == IDX_GAIN_STAT)
            || (i == IDX_LOCK_STAT) || (i == IDX_NV_VREF)
            || (i == IDX_NV_PDN) || (i == IDX_NV_GAIN_ADDR);
    endfunction

    function automatic logic [WORD_W-1:0] code_word(input logic [CODE_W-1:0] c);
        code_word = WORD_W'(c);
    endfunction

    assign idx = paddr[7:APB_IDX_LSB];
    assign mapped = is_mapped(idx);
    // channel lock freezes its volatile and stored code; address lock its nv word
    assign locked = pwrite && (((idx == IDX_DAC0 || idx == IDX_NV_DAC0) && cfg_reg[0])
        || ((idx == IDX_DAC1 || idx == IDX_NV_DAC1) && cfg_reg[2])
        || (idx == IDX_NV_GAIN_ADDR && cfg_reg[ADDR_LOCK_BIT]));
    // config bits writable only with the high voltage pin raised
    assign refuse = (state_reg != ST_RUN)
        || (idx == IDX_HV_CONFIG ? !(pwrite && hv_sync_reg) : !mapped)
        || locked;
    assign done = psel && penable && pready;
    assign wr_ok = done && pwrite && !pslverr;
    always_comb
    begin
        rword = '0;
        unique case (idx)
            IDX_DAC0: rword = code_word(dac_hold_reg[0]);
            IDX_DAC1: rword = code_word(dac_hold_reg[1]);
            IDX_VREF: rword = WORD_W'(vref_reg);
            IDX_PDN: rword = WORD_W'(pdn_reg);
            IDX_GAIN_STAT: rword = WORD_W'({gain_reg, por_flag_reg, 7'h00});
            IDX_LOCK_STAT: rword = WORD_W'(cfg_reg);
            IDX_NV_DAC0: rword = code_word(nv_dac_reg[0]);
            IDX_NV_DAC1: rword = code_word(nv_dac_reg[1]);
            IDX_NV_VREF: rword = WORD_W'(nv_vref_reg);
            IDX_NV_PDN: rword = WORD_W'(nv_pdn_reg);
            IDX_NV_GAIN_ADDR: rword = WORD_W'({nv_gain_reg, 1'b0, nv_addr_reg});
            default: rword = RSV_READ;
        endcase
        if (!mapped)
            rword = RSV_READ;
    end

    // answer one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && refuse;
            if (psel && penable && !pready)
                prdata <= (state_reg == ST_RUN) ? 32'(rword) : 32'h0000_0000;
        end
    end

    // ==========================================
    // memory pointer tracks last access completed without error
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            memory_pointer <= PTR_RESET;
        else if (por_event)
            memory_pointer <= PTR_RESET;
        else if (done && !pslverr)
            memory_pointer <= idx[4:0];
    end

    // ==========================================
    // volatile registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dac_hold_reg[0] <= CODE_ZERO;
            dac_hold_reg[1] <= CODE_ZERO;
            vref_reg <= SEL_RESET;
            pdn_reg <= PDN_SAFE;
            gain_reg <= GAIN_RESET;
        end
        else if (bor_event)
        begin
            dac_hold_reg[0] <= CODE_ZERO;
            dac_hold_reg[1] <= CODE_ZERO;
            pdn_reg <= PDN_SAFE;
            vref_reg <= SEL_RESET;
            gain_reg <= GAIN_RESET;
        end
        else if (por_event)
        begin
            dac_hold_reg[0] <= nv_dac_reg[0];
            dac_hold_reg[1] <= nv_dac_reg[1];
            vref_reg <= nv_vref_reg;
            pdn_reg <= nv_pdn_reg;
            gain_reg <= nv_gain_reg;
        end
        else if (wr_ok)
        begin
            unique case (idx)
                IDX_DAC0: dac_hold_reg[0] <= pwdata[CODE_W-1:0];
                IDX_DAC1: dac_hold_reg[1] <= pwdata[CODE_W-1:0];
                IDX_VREF: vref_reg <= pwdata[3:0];
                IDX_PDN: pdn_reg <= pwdata[3:0];
                IDX_GAIN_STAT: gain_reg <= pwdata[GAIN_LSB+1:GAIN_LSB];
                default: gain_reg <= gain_reg;
            endcase
        end
    end

    // flag cleared by writing zero; a rise always wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            por_flag_reg <= 1'b0;
        else if (por_event)
            por_flag_reg <= 1'b1;
        else if (wr_ok && idx == IDX_GAIN_STAT && !pwdata[POR_FLAG_BIT])
            por_flag_reg <= 1'b0;
    end

    // ==========================================
    // nonvolatile words and config bits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            nv_dac_reg[0] <= CODE_MID;
            nv_dac_reg[1] <= CODE_MID;
            nv_vref_reg <= SEL_RESET;
            nv_pdn_reg <= SEL_RESET;
            nv_gain_reg <= GAIN_RESET;
            nv_addr_reg <= SLAVE_ADDR_RESET;
            cfg_reg <= CFG_RESET;
            nv_write_pulse <= 1'b0;
        end
        else
        begin
            // write starts on the completing edge; volatile copy untouched
            nv_write_pulse <= wr_ok && (idx[5:4] != 2'b00) && !bor_event;
            if (wr_ok && !bor_event)
            begin
                unique case (idx)
                    IDX_NV_DAC0: nv_dac_reg[0] <= pwdata[CODE_W-1:0];
                    IDX_NV_DAC1: nv_dac_reg[1] <= pwdata[CODE_W-1:0];
                    IDX_NV_VREF: nv_vref_reg <= pwdata[3:0];
                    IDX_NV_PDN: nv_pdn_reg <= pwdata[3:0];
                    IDX_NV_GAIN_ADDR:
                    begin
                        nv_gain_reg <= pwdata[GAIN_LSB+1:GAIN_LSB];
                        nv_addr_reg <= pwdata[SLAVE_ADDR_W-1:0];
                    end
                    IDX_HV_CONFIG: cfg_reg <= pwdata[CFG_W-1:0];
                    default: nv_addr_reg <= nv_addr_reg;
                endcase
            end
        end
    end

    // ==========================================
    // output latch: strobe level passes held values through
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dac_code0 <= CODE_ZERO;
            dac_code1 <= CODE_ZERO;
            reference_source_select <= SEL_RESET;
            power_down_select <= PDN_SAFE;
            output_gain_select <= GAIN_RESET;
            interface_ready <= 1'b0;
        end
        else
        begin
            interface_ready <= (state_reg == ST_RUN);
            // safe state must not wait for the strobe
            if (state_reg == ST_OFF)
            begin
                dac_code0 <= CODE_ZERO;
                dac_code1 <= CODE_ZERO;
                reference_source_select <= SEL_RESET;
                power_down_select <= PDN_SAFE;
                output_gain_select <= GAIN_RESET;
            end
            else if (strobe_sync_reg || state_reg == ST_HOLD)
            begin
                dac_code0 <= dac_hold_reg[0];
                dac_code1 <= (CHANNELS == 2) ? dac_hold_reg[1] : CODE_ZERO;
                reference_source_select <= vref_reg;
                power_down_select <= pdn_reg;
                output_gain_select <= gain_reg;
            end
        end
    end

    // ==========================================
    // checks
    chk_por_flag: assert property (@(posedge pclk) disable iff (!presetn)
        por_event |=> por_flag_reg ##1 por_flag_reg)
        else $error("reset flag not set after rise");
    chk_por_pointer: assert property (@(posedge pclk) disable iff (!presetn)
        por_event |=> memory_pointer == PTR_RESET)
        else $error("pointer not zero after rise");
    chk_hold_refuse: assert property (@(posedge pclk) disable iff (!presetn)
        (pready && $past(state_reg) != ST_RUN) |-> pslverr)
        else $error("command accepted before hold-off end");
    chk_bor_off: assert property (@(posedge pclk) disable iff (!presetn)
        bor_event |=> state_reg == ST_OFF ##1 !interface_ready)
        else $error("interface alive after supply fall");
    chk_bor_pdn: assert property (@(posedge pclk) disable iff (!presetn)
        bor_event |=> pdn_reg == PDN_SAFE ##1 power_down_select == PDN_SAFE)
        else $error("power-down not forced on fall");
    chk_bor_code: assert property (@(posedge pclk) disable iff (!presetn)
        bor_event |=> dac_hold_reg[0] == CODE_ZERO && dac_hold_reg[1] == CODE_ZERO)
        else $error("codes not cleared on fall");
    chk_bor_sel: assert property (@(posedge pclk) disable iff (!presetn)
        bor_event |=> vref_reg == SEL_RESET && gain_reg == GAIN_RESET)
        else $error("reference or gain not cleared");
    chk_por_load: assert property (@(posedge pclk) disable iff (!presetn)
        por_event |=> dac_hold_reg[0] == $past(nv_dac_reg[0]))
        else $error("stored code not recalled");
    chk_cfg_load: assert property (@(posedge pclk) disable iff (!presetn)
        por_event |=> pdn_reg == $past(nv_pdn_reg) && vref_reg == $past(nv_vref_reg))
        else $error("stored config not recalled");
    chk_nv_block: assert property (@(posedge pclk) disable iff (!presetn)
        nv_write_pulse |-> $past(state_reg, 2) == ST_RUN && $past(sg_sync_reg))
        else $error("stored write outside run");
    cov_rise: cover property (@(posedge pclk) disable iff (!presetn)
        por_event ##[1:300] state_reg == ST_RUN);
    cov_fall: cover property (@(posedge pclk) disable iff (!presetn) bor_event);
    cov_nv_write: cover property (@(posedge pclk) disable iff (!presetn) nv_write_pulse);
    cov_reserved: cover property (@(posedge pclk) disable iff (!presetn)
        pready && pslverr && !mapped && state_reg == ST_RUN);
endmodule

// ---- sim/apb_host_model.sv ----
/*
 apb master standing in for the host that reaches the converter memory.
 assumes one pclk domain; the bench calls xfer one access at a time.
*/
`timescale 1ns/1ps
module apb_host_model
(
    input wire logic pclk,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    output logic [7:0] paddr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] pwdata
);
    // ==========================================
    // bus cycle
    initial
    begin
        paddr = 8'h00;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0000_0000;
    end

    // request held until pready is sampled; only the bench watchdog ends a hung wait
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        @(posedge pclk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// ---- sim/testbench.sv ----
/*
 self-checking bench for the supply sequencer and register memory.
 assumes the apb host model and the design package; hold-off shortened.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; \
    $display("ERROR %0t: got %h expected %h", $time, (g), (e)); end end
module testbench;
    import dac_supply_pkg::*;
    localparam int CW = 12;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic supply_good = 1'b0;
    logic strobe = 1'b0;
    logic hv = 1'b0;
    logic [7:0] paddr;
    logic psel, penable, pwrite, pready, pslverr, interface_ready, nv_write_pulse, err;
    logic [31:0] pwdata, prdata, rd;
    logic [31:0] seed = 32'h0000_51ad;
    logic [CW-1:0] dac_code0, dac_code1, c0, c1, p0, p1;
    logic [CW-1:0] nv0 = 12'h5a3;
    logic [3:0] reference_source_select, power_down_select;
    logic [1:0] output_gain_select;
    logic [4:0] memory_pointer;
    logic [5:0] resv[7] = '{6'h02, 6'h07, 6'h0c, 6'h0f, 6'h12, 6'h1b, 6'h1f};
    int fails = 0;
    int n_tests = 0;
    int n_nv = 0;
    int n0;

    always #10 pclk = ~pclk;

    dac_supply_reset_memory_init #(.CODE_W(CW), .CHANNELS(2), .PORD_CYCLES(8)) u_dut (.pclk(pclk),
        .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .supply_good(supply_good),
        .output_update_strobe(strobe), .high_voltage_command_input(hv), .dac_code0(dac_code0),
        .dac_code1(dac_code1), .reference_source_select(reference_source_select),
        .power_down_select(power_down_select), .output_gain_select(output_gain_select),
        .interface_ready(interface_ready), .nv_write_pulse(nv_write_pulse), .memory_pointer(memory_pointer));

    apb_host_model u_host (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata));

    always @(posedge pclk)
        if (nv_write_pulse === 1'b1)
            n_nv <= n_nv + 1;

    // ==========================================
    // helpers
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    function automatic logic [CW-1:0] mid_code();
        return {1'b0, {(CW-1){1'b1}}};
    endfunction

    task automatic acc(input logic [5:0] idx, input logic w, input logic [31:0] d, input logic exp_err);
        u_host.xfer({idx, 2'b00}, w, d, rd, err);
        `CHK(err, exp_err)
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // bounded wait on the design's own ready level
    task automatic wait_ready();
        for (int k = 0; k < 60 && interface_ready !== 1'b1; k++)
            @(posedge pclk);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ==========================================
    // sequence
    initial
    begin
        repeat (20000) @(posedge pclk);
        fails++;
        give_verdict();
    end

    initial
    begin
        settle(2);
        presetn <= 1'b1;
        acc(IDX_DAC0, 1'b0, 32'h0, 1'b1);
        `CHK(rd, 32'h0)
        `CHK(power_down_select, PDN_SAFE)
        supply_good <= 1'b1;
        strobe <= 1'b1;
        settle(2);
        acc(IDX_VREF, 1'b1, 32'h5, 1'b1);
        `CHK(interface_ready, 1'b0)
        wait_ready();
        `CHK(interface_ready, 1'b1)
        `CHK(memory_pointer, PTR_RESET)
        `CHK(dac_code0, mid_code())
        `CHK(dac_code1, mid_code())
        `CHK(reference_source_select, SEL_RESET)
        acc(IDX_GAIN_STAT, 1'b0, 32'h0, 1'b0);
        `CHK(rd, 32'h0000_0080)
        p0 = mid_code();
        p1 = mid_code();
        // held codes must not reach the outputs while the strobe is low
        for (int i = 0; i < 4; i++)
        begin
            seed = xorshift(seed);
            c0 = (i == 0) ? '1 : (i == 1) ? '0 : seed[CW-1:0];
            c1 = seed[CW+15:16];
            strobe <= 1'b0;
            settle(4);
            acc(IDX_DAC0, 1'b1, {20'h0, c0}, 1'b0);
            acc(IDX_DAC1, 1'b1, {20'h0, c1}, 1'b0);
            acc(IDX_DAC0, 1'b0, 32'h0, 1'b0);
            `CHK(rd, {20'h0, c0})
            `CHK(dac_code0, p0)
            `CHK(dac_code1, p1)
            strobe <= 1'b1;
            settle(5);
            `CHK(dac_code0, c0)
            `CHK(dac_code1, c1)
            p0 = c0;
            p1 = c1;
        end
        foreach (resv[i])
        begin
            acc(resv[i], 1'b0, 32'h0, 1'b1);
            `CHK(rd, {20'h0, {CW{1'b1}}})
            acc(resv[i], 1'b1, 32'hffff_ffff, 1'b1);
        end
        for (int v = 0; v < 4; v++)
        begin
            acc(IDX_VREF, 1'b1, {28'h0, 2'(3 - v), 2'(v)}, 1'b0);
            settle(4);
            `CHK(reference_source_select, {2'(3 - v), 2'(v)})
            acc(IDX_GAIN_STAT, 1'b1, {22'h0, 2'(v), 8'h00}, 1'b0);
            settle(4);
            `CHK(output_gain_select, 2'(v))
        end
        n0 = n_nv;
        acc(IDX_NV_DAC0, 1'b1, {20'h0, nv0}, 1'b0);
        settle(2);
        `CHK(n_nv, n0 + 1)
        `CHK(memory_pointer, 5'h10)
        acc(IDX_DAC0, 1'b0, 32'h0, 1'b0);
        `CHK(rd, {20'h0, p0})
        acc(IDX_NV_VREF, 1'b1, 32'h6, 1'b0);
        acc(IDX_NV_PDN, 1'b1, 32'h1, 1'b0);
        acc(IDX_NV_GAIN_ADDR, 1'b1, 32'h0000_0360, 1'b0);
        // brown-out: the note fixes sync plus two edges, six leaves margin
        supply_good <= 1'b0;
        settle(6);
        `CHK(power_down_select, PDN_SAFE)
        `CHK(dac_code0, 12'h000)
        `CHK(dac_code1, 12'h000)
        `CHK(reference_source_select, SEL_RESET)
        `CHK(output_gain_select, GAIN_RESET)
        `CHK(interface_ready, 1'b0)
        n0 = n_nv;
        acc(IDX_NV_DAC1, 1'b1, 32'h0, 1'b1);
        settle(2);
        `CHK(n_nv, n0)
        supply_good <= 1'b1;
        wait_ready();
        `CHK(interface_ready, 1'b1)
        `CHK(dac_code0, nv0)
        `CHK(dac_code1, mid_code())
        `CHK(reference_source_select, 4'h6)
        `CHK(power_down_select, 4'h1)
        `CHK(output_gain_select, 2'b11)
        `CHK(memory_pointer, PTR_RESET)
        acc(IDX_GAIN_STAT, 1'b0, 32'h0, 1'b0);
        `CHK(rd, 32'h0000_0380)
        acc(IDX_HV_CONFIG, 1'b1, 32'h1, 1'b1);
        hv <= 1'b1;
        settle(4);
        acc(IDX_HV_CONFIG, 1'b1, 32'h1, 1'b0);
        hv <= 1'b0;
        settle(4);
        acc(IDX_DAC0, 1'b1, 32'h5, 1'b1);
        acc(IDX_LOCK_STAT, 1'b0, 32'h0, 1'b0);
        `CHK(rd[0], 1'b1)
        give_verdict();
    end
endmodule
